/* core/pof_formatter.sv */
// Pixel output formatter: converts pipeline pixels to YUV, YCbCr, RGB or raw byte streams.
// Assumes pixel inputs come from logic on core_clk and an AXI4-Lite master on the same clock.
// Assumes frameStart is a one-cycle pulse ahead of the first pixel of each frame.
//
// Overview of operation
// [RULE_01] Pipeline YUV passes unchanged, or is converted to a chosen YUV/YCbCr/RGB form.
// [RULE_02] BT.601 full range: Y=.299R+.587G+.114B, U=.564(B-Y)+128, V=.713(R-Y)+128.
// [RULE_03] An option drops the 128 chroma offset in full-range YUV modes.
// [RULE_04] sRGB YCbCr luma uses sRGB weights scaled by 219/256 plus 16.
// [RULE_05] sRGB YCbCr Cb=.5389(B-Y), Cr=.635(R-Y), scaled by 224/256 plus 128.
// [RULE_06] sRGB YCbCr keeps luma in 16..235 and chroma in 16..240.
// [RULE_07] sRGB full range: sRGB luma, U=.5389(B-Y)+128, V=.635(R-Y)+128, 0..255.
// [RULE_08] 4:2:2 order Cb,Y0,Cr,Y1, with chroma swap and luma/chroma swap variants.
// [RULE_09] RGB output swaps odd and even bytes when luma/chroma swap is set.
// [RULE_10] RGB output exchanges red and blue when chroma swap is set.
// [RULE_11] 565 and 555 packing of the odd and even bytes.
// [RULE_12] 444x and x444 packing of the odd and even bytes.
// [RULE_13] Raw 10-bit bypass on byte port plus two low bits, or byte port only.
// [RULE_14] Two-byte raw: bits 9..2 first, then six zeros and bits 1..0.
// [RULE_15] Every conversion result is rounded to nearest and saturated to its range.
// [RULE_16] Settings change only between frames so each frame has one format.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pof_consts.svh"

module pof_formatter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`POF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`POF_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frameStart,
  input wire logic pixValid,
  input wire pof_pkg::pof_pix_s pixIn,
  output logic pixReady,
  output logic [7:0] dout,
  output logic [1:0] doutLsb,
  output logic doutValid
);

  // Everything the block remembers lives in one packed struct, so the clock
  // enable and the reset reach a single register and nothing can be missed
  pof_pkg::pof_state_s state_r;
  pof_pkg::pof_state_s state_nxt;

  // Zero-extend a byte into the wide signed arithmetic domain
  // Forty-one bits hold the largest product: a byte difference times two gains
  function automatic logic signed [40:0] ext8(input logic [7:0] v);
    ext8 = $signed({33'h0, v});
  endfunction

  // Round to nearest by adding half an LSB before the arithmetic shift
  // Ties go upward for negative values too; the bias is below half a code
  // and cheaper than a sign-dependent rounding step
  function automatic logic signed [40:0] rnd(input logic signed [40:0] v, input int unsigned sh);
    logic signed [40:0] half;
    half = 41'sh1 <<< (sh - 1);
    rnd = (v + half) >>> sh;
  endfunction

  // Clip to [lo, hi] and keep the low byte (two's complement for signed ranges)
  // The signed clip keeps chroma without offset in two's complement form
  function automatic logic [7:0] sat8(input logic signed [40:0] v, input int lo, input int hi);
    logic signed [40:0] c;
    c = v;
    if (v < 41'(lo)) begin
      c = 41'(lo);
    end else if (v > 41'(hi)) begin
      c = 41'(hi);
    end
    sat8 = c[7:0];
  endfunction

  // Pack one RGB pixel as first byte then second byte, no swaps applied
  // Swaps are done by the caller so one table serves all four swap settings
  function automatic logic [15:0] packRgb(input pof_pkg::pof_fmt_e f, input logic [7:0] r,
                                          input logic [7:0] g, input logic [7:0] b);
    packRgb = 16'h0;
    unique case (f)
      pof_pkg::FMT_RGB565: packRgb = {r[7:3], g[7:5], g[4:2], b[7:3]}; // RULE_11
      pof_pkg::FMT_RGB555: packRgb = {1'b0, r[7:3], g[7:6], g[4:2], b[7:3]}; // RULE_11
      pof_pkg::FMT_RGB444X: packRgb = {r[7:4], g[7:4], b[7:4], 4'h0}; // RULE_12
      pof_pkg::FMT_RGBX444: packRgb = {4'h0, r[7:4], g[7:4], b[7:4]}; // RULE_12
      default: packRgb = 16'h0;
    endcase
  endfunction

  // Whole next-state computation: bus slave, config, conversion and byte sequencing
  always_comb begin
    logic [7:0] cfg;
    pof_pkg::pof_fmt_e fmt;
    logic cSwap;
    logic ycSwap;
    logic noOfs;
    logic signed [40:0] chromaOfs;
    logic signed [40:0] cMin;
    logic signed [40:0] yq601;
    logic signed [40:0] yqSrgb;
    logic signed [40:0] dB601;
    logic signed [40:0] dR601;
    logic signed [40:0] dBs;
    logic signed [40:0] dRs;
    logic [7:0] yB;
    logic [7:0] cbB;
    logic [7:0] crB;
    logic [7:0] rgbR;
    logic [7:0] rgbB;
    logic [15:0] pair;
    logic accept;
    logic twoByte;
    logic wrHit;
    cfg = 8'h0;
    fmt = pof_pkg::FMT_PASS;
    cSwap = 1'b0;
    ycSwap = 1'b0;
    noOfs = 1'b0;
    chromaOfs = 41'sh0;
    cMin = 41'sh0;
    yq601 = 41'sh0;
    yqSrgb = 41'sh0;
    dB601 = 41'sh0;
    dR601 = 41'sh0;
    dBs = 41'sh0;
    dRs = 41'sh0;
    yB = 8'h0;
    cbB = 8'h0;
    crB = 8'h0;
    rgbR = 8'h0;
    rgbB = 8'h0;
    pair = 16'h0;
    accept = 1'b0;
    twoByte = 1'b0;
    wrHit = 1'b0;
    state_nxt = state_r;

    // Readies drop while a half is held, so a second address cannot overwrite the first
    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && state_r.awready) begin
      state_nxt.awHeld = 1'b1;
      state_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_r.wready) begin
      state_nxt.wHeld = 1'b1;
      state_nxt.wdata = s_axi_wdata[7:0];
      state_nxt.wstrb0 = s_axi_wstrb[0];
    end
    // Once both halves are held, commit and answer; only byte lane 0 carries fields
    // Commit waits for the response to clear, so one write is under way at a time
    if (state_r.awHeld && state_r.wHeld && !state_r.bvalid) begin
      wrHit = (state_r.awaddr == `POF_OFS_CTRL);
      if (wrHit && state_r.wstrb0) begin
        state_nxt.ctrl = state_r.wdata & `POF_CTRL_WMASK;
      end
      state_nxt.bresp = (wrHit || state_r.awaddr == `POF_OFS_STATUS) ? `POF_RESP_OKAY : `POF_RESP_SLVERR;
      state_nxt.bvalid = 1'b1;
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address; unmapped reads give zero and SLVERR
    // A read never waits on the pixel path, so software may poll the pixel count freely
    if (s_axi_arvalid && state_r.arready) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = `POF_RESP_OKAY;
      if (s_axi_araddr == `POF_OFS_CTRL) begin
        state_nxt.rdata = {24'h0, state_r.ctrl};
      end else if (s_axi_araddr == `POF_OFS_STATUS) begin
        state_nxt.rdata = {8'h0, state_r.act, state_r.pixCnt};
      end else begin
        state_nxt.rdata = 32'h0;
        state_nxt.rresp = `POF_RESP_SLVERR;
      end
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end

    // Settings are latched at frame start; the pixel of that cycle already uses them
    // Latching here means a write in mid-frame cannot tear the output format
    // The active copy is also what the status register reports back
    cfg = frameStart ? state_r.ctrl : state_r.act; // RULE_16
    if (frameStart) begin
      state_nxt.act = state_r.ctrl; // RULE_16
      state_nxt.pixCnt = 16'h0;
      state_nxt.parity = 1'b0;
    end
    fmt = pof_pkg::pof_fmt_e'(cfg[`POF_CTRL_FMT_HI:`POF_CTRL_FMT_LO]);
    cSwap = cfg[`POF_CTRL_CSWAP];
    ycSwap = cfg[`POF_CTRL_YCSWAP];
    noOfs = cfg[`POF_CTRL_NOOFS];

    // Chroma offset is optional only in the full-range modes
    // Studio mode always centres chroma on the offset, whatever the option bit says
    chromaOfs = noOfs ? 41'sh0 : 41'(`POF_CHROMA_OFS); // RULE_03
    cMin = noOfs ? 41'(`POF_SGN_MIN) : 41'(`POF_FULL_MIN); // RULE_03

    // Luma sums kept at 1/1024 precision so chroma sees the unrounded luma
    // The products stay exact; only the final shift rounds, so no error accumulates
    yq601 = ext8(pixIn.r) * `POF_K601_R + ext8(pixIn.g) * `POF_K601_G + ext8(pixIn.b) * `POF_K601_B; // RULE_02
    yqSrgb = ext8(pixIn.r) * `POF_KSRGB_R + ext8(pixIn.g) * `POF_KSRGB_G
             + ext8(pixIn.b) * `POF_KSRGB_B; // RULE_04
    // Differences against the unrounded luma avoid a double rounding step
    dB601 = (ext8(pixIn.b) <<< `POF_Q) - yq601;
    dR601 = (ext8(pixIn.r) <<< `POF_Q) - yq601;
    dBs = (ext8(pixIn.b) <<< `POF_Q) - yqSrgb;
    dRs = (ext8(pixIn.r) <<< `POF_Q) - yqSrgb;

    // Luma and chroma bytes for the YUV family; every converted result rounded then clipped, pass-through bytes taken as they come
    unique case (fmt)
      pof_pkg::FMT_YUV601: begin
        yB = sat8(rnd(yq601, `POF_Q), `POF_FULL_MIN, `POF_FULL_MAX); // RULE_02 RULE_15
        cbB = sat8(rnd(dB601 * `POF_K601_U, `POF_Q2) + chromaOfs, int'(cMin),
                   noOfs ? `POF_SGN_MAX : `POF_FULL_MAX); // RULE_02 RULE_15
        crB = sat8(rnd(dR601 * `POF_K601_V, `POF_Q2) + chromaOfs, int'(cMin),
                   noOfs ? `POF_SGN_MAX : `POF_FULL_MAX); // RULE_02 RULE_15
      end
      pof_pkg::FMT_YCBCR_SRGB: begin
        yB = sat8(rnd(yqSrgb * `POF_STUDIO_YGAIN, `POF_Q_STUDIO_Y) + `POF_STUDIO_YOFS,
                  `POF_STUDIO_MIN, `POF_STUDIO_YMAX); // RULE_04 RULE_06
        cbB = sat8(rnd(dBs * `POF_KSRGB_CB * `POF_STUDIO_CGAIN, `POF_Q_STUDIO_C) + `POF_CHROMA_OFS,
                   `POF_STUDIO_MIN, `POF_STUDIO_CMAX); // RULE_05 RULE_06
        crB = sat8(rnd(dRs * `POF_KSRGB_CR * `POF_STUDIO_CGAIN, `POF_Q_STUDIO_C) + `POF_CHROMA_OFS,
                   `POF_STUDIO_MIN, `POF_STUDIO_CMAX); // RULE_05 RULE_06
      end
      pof_pkg::FMT_YUV_SRGB: begin
        yB = sat8(rnd(yqSrgb, `POF_Q), `POF_FULL_MIN, `POF_FULL_MAX); // RULE_07 RULE_15
        cbB = sat8(rnd(dBs * `POF_KSRGB_CB, `POF_Q2) + chromaOfs, int'(cMin),
                   noOfs ? `POF_SGN_MAX : `POF_FULL_MAX); // RULE_07
        crB = sat8(rnd(dRs * `POF_KSRGB_CR, `POF_Q2) + chromaOfs, int'(cMin),
                   noOfs ? `POF_SGN_MAX : `POF_FULL_MAX); // RULE_07
      end
      default: begin
        // Pass-through, and the unused value in RGB and raw modes
        yB = pixIn.y; // RULE_01
        cbB = pixIn.u;
        crB = pixIn.v;
      end
    endcase

    // Assemble the two bytes this pixel contributes, first byte in pair[15:8]
    // Chroma swap exchanges red and blue before packing, luma/chroma swap the bytes after
    rgbR = cSwap ? pixIn.b : pixIn.r; // RULE_10
    rgbB = cSwap ? pixIn.r : pixIn.b; // RULE_10
    twoByte = 1'b1;
    unique case (fmt)
      pof_pkg::FMT_PASS, pof_pkg::FMT_YUV601, pof_pkg::FMT_YCBCR_SRGB, pof_pkg::FMT_YUV_SRGB: begin
        // Even pixel carries the first chroma of the pair, odd pixel the second
        // Each pixel sends its own chroma; no averaging across the pair is done
        if (state_nxt.parity ^ cSwap) begin
          pair = ycSwap ? {yB, crB} : {crB, yB}; // RULE_08
        end else begin
          pair = ycSwap ? {yB, cbB} : {cbB, yB}; // RULE_08
        end
      end
      pof_pkg::FMT_RGB565, pof_pkg::FMT_RGB555, pof_pkg::FMT_RGB444X, pof_pkg::FMT_RGBX444: begin
        pair = packRgb(fmt, rgbR, pixIn.g, rgbB);
        if (ycSwap) begin
          pair = {pair[7:0], pair[15:8]}; // RULE_09
        end
      end
      pof_pkg::FMT_RAW10: begin
        pair = {pixIn.raw[9:2], 8'h0}; // RULE_13
        twoByte = 1'b0;
      end
      pof_pkg::FMT_RAW8P2: begin
        pair = {pixIn.raw[9:2], 6'h0, pixIn.raw[1:0]}; // RULE_13 RULE_14
      end
      default: begin
        // Unused format codes output nothing but still consume the pixel
        // Limitation: such a frame is lost silently, so software must not select them
        pair = 16'h0;
        twoByte = 1'b0;
      end
    endcase

    // Byte sequencer: first byte now, second byte next cycle while input is held off
    // The host cannot stall, so the only throttle is pixReady toward the pipeline
    accept = pixValid && state_r.ready;
    state_nxt.doutValid = 1'b0;
    state_nxt.lsb = 2'h0;
    if (state_r.pendValid) begin
      state_nxt.dout = state_r.pend;
      state_nxt.doutValid = 1'b1;
      state_nxt.pendValid = 1'b0;
    end else if (accept) begin
      state_nxt.dout = pair[15:8];
      state_nxt.doutValid = (fmt <= pof_pkg::FMT_RAW8P2);
      state_nxt.lsb = (fmt == pof_pkg::FMT_RAW10) ? pixIn.raw[1:0] : 2'h0; // RULE_13
      state_nxt.pend = pair[7:0];
      state_nxt.pendValid = twoByte;
      state_nxt.parity = ~state_nxt.parity;
      state_nxt.pixCnt = state_nxt.pixCnt + 16'h1;
    end
    // A pixel is refused only while its second byte is still to go
    // Raw with low bits and unused codes never hold the pipeline off
    state_nxt.ready = !state_nxt.pendValid;

    // Bus readies follow from what is held, so the outputs stay registered
    // Taken from the next state, they never offer a slot the register cannot fill
    state_nxt.awready = !state_nxt.awHeld && !state_nxt.bvalid;
    state_nxt.wready = !state_nxt.wHeld && !state_nxt.bvalid;
    state_nxt.arready = !state_nxt.rvalid;
  end

  // One register for all state; clkEn low freezes everything
  // A low enable also freezes the bus outputs, so handshakes a master completes meanwhile are not registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{ctrl: `POF_CTRL_RST, default: '0};
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  // No output is combinational, which keeps timing at the block edge simple
  assign s_axi_awready = state_r.awready;
  assign s_axi_wready = state_r.wready;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_arready = state_r.arready;
  assign s_axi_rdata = state_r.rdata;
  assign s_axi_rresp = state_r.rresp;
  assign s_axi_rvalid = state_r.rvalid;
  assign pixReady = state_r.ready;
  assign dout = state_r.dout;
  assign doutLsb = state_r.lsb;
  assign doutValid = state_r.doutValid;

endmodule

/* core/pof_consts.svh */
// Named constants for the pixel output formatter: register map, fields, reset values,
// conversion coefficients and output ranges. Included by the package and the formatter.
`ifndef POF_CONSTS_SVH
`define POF_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define POF_OFS_CTRL 8'h00
`define POF_OFS_STATUS 8'h04
`define POF_ADDR_W 8

// Control register fields
`define POF_CTRL_FMT_HI 3
`define POF_CTRL_FMT_LO 0
`define POF_CTRL_CSWAP 4
`define POF_CTRL_YCSWAP 5
`define POF_CTRL_NOOFS 6
`define POF_CTRL_RST 8'h00
`define POF_CTRL_WMASK 8'h7f

// AXI responses
`define POF_RESP_OKAY 2'h0
`define POF_RESP_SLVERR 2'h2

// Fixed point: luma weights and chroma gains in units of 1/1024, studio gains in 1/256
`define POF_Q 10
`define POF_Q2 20
`define POF_Q_STUDIO_Y 18
`define POF_Q_STUDIO_C 28
`define POF_K601_R 306
`define POF_K601_G 601
`define POF_K601_B 117
`define POF_K601_U 578
`define POF_K601_V 730
`define POF_KSRGB_R 218
`define POF_KSRGB_G 732
`define POF_KSRGB_B 74
`define POF_KSRGB_CB 552
`define POF_KSRGB_CR 650
`define POF_STUDIO_YGAIN 219
`define POF_STUDIO_CGAIN 224

// Output offsets and ranges
`define POF_CHROMA_OFS 128
`define POF_STUDIO_YOFS 16
`define POF_FULL_MIN 0
`define POF_FULL_MAX 255
`define POF_SGN_MIN (-128)
`define POF_SGN_MAX 127
`define POF_STUDIO_MIN 16
`define POF_STUDIO_YMAX 235
`define POF_STUDIO_CMAX 240

`endif

/* core/pof_pkg.sv */
// Types shared by the pixel output formatter and its bench.
// Assumes pof_consts.svh sits beside it on the include path.
`include "pof_consts.svh"

package pof_pkg;

  // Output format selected by the control register format field
  typedef enum logic [3:0] {
    FMT_PASS,
    FMT_YUV601,
    FMT_YCBCR_SRGB,
    FMT_YUV_SRGB,
    FMT_RGB565,
    FMT_RGB555,
    FMT_RGB444X,
    FMT_RGBX444,
    FMT_RAW10,
    FMT_RAW8P2
  } pof_fmt_e;

  // One pixel from the colour pipeline, with the matching raw sample
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
    logic [9:0] raw;
  } pof_pix_s;

  // Entire state of the formatter
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] act;
    logic [15:0] pixCnt;
    logic parity;
    logic [7:0] pend;
    logic pendValid;
    logic ready;
    logic [7:0] dout;
    logic [1:0] lsb;
    logic doutValid;
    logic awready;
    logic wready;
    logic awHeld;
    logic wHeld;
    logic [`POF_ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pof_state_s;

endpackage

/* verification/pof_checker.sv */
// Checker for the pixel output formatter: stream pacing, raw bypass and AXI4-Lite timing.
// Assumes it is bound to the formatter and sees only its ports.
`timescale 1ns/1ps
module pof_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixValid,
  input wire pof_pkg::pof_pix_s pixIn,
  input wire logic pixReady,
  input wire logic [7:0] dout,
  input wire logic [1:0] doutLsb,
  input wire logic doutValid
);
  logic [9:0] rawIn;
  // Raw sample pulled out so its history can be sampled
  assign rawIn = pixIn.raw;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Two-byte pixel: ready is low only while the first byte is out
  sequence twoBytes;
    doutValid ##1 (doutValid && pixReady);
  endsequence
  // Read response retires and the address channel reopens in the same cycle;
  // a later check would trip when the master starts its next read at once
  sequence readDone;
    !s_axi_rvalid && s_axi_arready;
  endsequence
  AST_TWO_BYTE: assert property ($fell(pixReady) |-> twoBytes)
    else $error("two-byte pixel did not give two bytes");
  AST_STALL_CAUSE: assert property ($fell(pixReady) |-> $past(pixValid))
    else $error("pixel ready dropped without a pixel");
  AST_OUT_CAUSE: assert property (doutValid && $past(pixReady) |-> $past(pixValid))
    else $error("byte out without a pixel taken");
  AST_RAW10_LSB: assert property (doutLsb != 2'h0 |-> doutValid && pixReady && $past(rawIn) == {dout, doutLsb})
    else $error("low raw bits do not match the sample");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> readDone)
    else $error("read channel not reopened");
endmodule

bind pof_formatter pof_checker chk (.core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pixValid, .pixIn, .pixReady, .dout, .doutLsb, .doutValid);

/* verification/pof_host_rx.sv */
// Host receiver model: collects every byte the formatter presents, with its low raw bits.
// Assumes one byte per cycle on core_clk; the host cannot push back on the stream.
`timescale 1ns/1ps
module pof_host_rx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] dout,
  input wire logic [1:0] doutLsb,
  input wire logic doutValid
);
  logic [9:0] q[$];
  // Capture each valid byte; the bench drains the queue between frames
  always @(posedge core_clk) begin
    if (rst_n && doutValid) begin
      q.push_back({doutLsb, dout});
    end
  end
endmodule

/* verification/pixel_output_formatter_bench.sv */
// Bench for the pixel output formatter: registers, byte order, RGB packing, raw bypass, conversion.
// Assumes the formatter, the host receiver model and the bound checker are compiled with it.
`timescale 1ns/1ps
module pixel_output_formatter_bench;
  logic core_clk = 1'h0, rst_n = 1'h0, clkEn = 1'h1, frameStart = 1'h0, pixValid = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dout;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  pof_pkg::pof_pix_s pixIn = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pixReady, doutValid;
  logic [1:0] s_axi_bresp, s_axi_rresp, doutLsb;
  int n_errors = 0, checks_done = 0, cyc = 0;

  pof_formatter uut (.core_clk, .rst_n, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frameStart,
    .pixValid, .pixIn, .pixReady, .dout, .doutLsb, .doutValid);
  pof_host_rx rx (.core_clk, .rst_n, .dout, .doutLsb, .doutValid);

  // 10 MHz clock
  initial forever #50 core_clk = ~core_clk;

  task automatic results;
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released once its own ready is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw = 1'h1, w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end while (aw || w);
    do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  function automatic pof_pkg::pof_pix_s px(input logic [7:0] r, g, b, y, u, v, input logic [9:0] w);
    return '{r, g, b, y, u, v, w};
  endfunction

  // Pixel held until the edge that samples ready high
  task automatic send(input pof_pkg::pof_pix_s p);
    pixValid <= 1'h1;
    pixIn <= p;
    @(posedge core_clk);
    while (pixReady !== 1'h1) @(posedge core_clk);
  endtask

  // Settings are written before the frame start, never inside a frame
  task automatic frame(input logic [7:0] c, input pof_pkg::pof_pix_s p0, p1, input logic [9:0] e[4], input int n);
    logic [1:0] r;
    axw(8'h00, {24'h0, c}, r);
    chk(r, 2'h0);
    frameStart <= 1'h1;
    @(posedge core_clk);
    frameStart <= 1'h0;
    rx.q.delete();
    send(p0);
    send(p1);
    pixValid <= 1'h0;
    repeat (4) @(posedge core_clk);
    chk(rx.q.size(), n);
    for (int i = 0; i < n; i++) chk(rx.q[i], e[i]);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h00, d, r);
    chk(d, 32'h0);
    axr(8'h08, d, r);
    chk(r, 2'h2);
    axw(8'h08, 32'h5, r);
    chk(r, 2'h2);
    axw(8'h00, 32'hffffff85, r);
    s_axi_wstrb <= 4'he;
    axw(8'h00, 32'h3, r);
    s_axi_wstrb <= 4'hf;
    axr(8'h00, d, r);
    chk(d, 32'h5);
  endtask

  task automatic t_yuv;
    logic [9:0] e[4][4] = '{'{10'h20, 10'h10, 10'h60, 10'h40}, '{10'h30, 10'h10, 10'h50, 10'h40},
      '{10'h10, 10'h20, 10'h40, 10'h60}, '{10'h10, 10'h30, 10'h40, 10'h50}};
    for (int s = 0; s < 4; s++) begin
      frame({2'h0, s[1:0], 4'h0}, px(8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h30, 10'h0),
        px(8'h00, 8'h00, 8'h00, 8'h40, 8'h50, 8'h60, 10'h0), e[s], 4);
    end
  endtask

  // Expected RGB pair, chroma swap exchanging R and B, luma/chroma swap the bytes
  function automatic logic [15:0] pack(input logic [3:0] f, input logic [1:0] s, input logic [7:0] r, g, b);
    logic [7:0] t;
    logic [15:0] o;
    t = r;
    if (s[0]) begin
      r = b;
      b = t;
    end
    case (f)
      4'h4: o = {r[7:3], g[7:5], g[4:2], b[7:3]};
      4'h5: o = {1'h0, r[7:3], g[7:6], g[4:2], b[7:3]};
      4'h6: o = {r[7:4], g[7:4], b[7:4], 4'h0};
      default: o = {4'h0, r[7:4], g[7:4], b[7:4]};
    endcase
    return s[1] ? {o[7:0], o[15:8]} : o;
  endfunction

  task automatic t_rgb;
    pof_pkg::pof_pix_s a = px(8'ha5, 8'h3c, 8'h96, 8'h00, 8'h00, 8'h00, 10'h0);
    pof_pkg::pof_pix_s c = px(8'h5a, 8'hc3, 8'h69, 8'h00, 8'h00, 8'h00, 10'h0);
    logic [15:0] x, y;
    for (int f = 4; f < 8; f++) begin
      for (int s = 0; s < 4; s++) begin
        x = pack(f[3:0], s[1:0], a.r, a.g, a.b);
        y = pack(f[3:0], s[1:0], c.r, c.g, c.b);
        frame({2'h0, s[1:0], f[3:0]}, a, c, '{{2'h0, x[15:8]}, {2'h0, x[7:0]}, {2'h0, y[15:8]},
          {2'h0, y[7:0]}}, 4);
      end
    end
  endtask

  task automatic t_raw;
    pof_pkg::pof_pix_s a = px(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 10'h2b5);
    pof_pkg::pof_pix_s c = px(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 10'h14e);
    logic [31:0] d;
    logic [1:0] r;
    frame(8'h09, a, c, '{10'h0ad, 10'h001, 10'h053, 10'h002}, 4);
    frame(8'h08, a, c, '{10'h1ad, 10'h253, 10'h000, 10'h000}, 2);
    // Status shows the latched setting and the pixels taken since frame start
    axr(8'h04, d, r);
    chk(d, 32'h00080002);
    // An unused format code swallows pixels and sends nothing
    frame(8'h0a, a, c, '{4{10'h0}}, 0);
    axr(8'h04, d, r);
    chk(d, 32'h000a0002);
  endtask

  // Grey and saturated red: control, R, G, B, then expected chroma, luma, chroma
  task automatic t_conv;
    logic [55:0] t[7] = '{56'h01646464806480, 56'h01ff0000554cff, 56'h41ff0000d54c7f, 56'h02ffffff80ea80,
      56'h02000000801080, 56'h03ff00006336ff, 56'h43ff0000e3367f};
    pof_pkg::pof_pix_s p;
    for (int i = 0; i < 7; i++) begin
      p = px(t[i][47:40], t[i][39:32], t[i][31:24], 8'h00, 8'h00, 8'h00, 10'h0);
      frame(t[i][55:48], p, p, '{{2'h0, t[i][23:16]}, {2'h0, t[i][15:8]}, {2'h0, t[i][7:0]},
        {2'h0, t[i][15:8]}}, 4);
    end
  endtask

  // Reset for three cycles, first request after the edge that opens the readies
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    t_regs();
    t_yuv();
    t_rgb();
    t_raw();
    t_conv();
    results();
  end

  // Hang guard, well above the few hundred cycles the frames need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
endmodule
